// *** hub_power_port_config.v ***
// Purpose: configuration bytes 0x7..0xc of a two-port hub
// Assumes: loader (EEPROM or SMBus) writes bytes before attach
// Notes: outputs show the settings for the current power mode
`timescale 1ns/10ps
`include "hub_cfg_map.vh"

// Notes on behaviour
// - dynamic bit enables automatic self/bus switching
// - two-bit field selects over-current delay
// - bit 3 marks compound device
// - bits 1,2 flag ports non-removable
// - self-powered byte disables ports 1,2
// - bus-powered byte disables ports 1,2
// - self-powered current byte in 2 mA units
// - bus-powered current byte in 2 mA units
// - dynamic mode ignores select bit, uses sense
// - non-removable flags only for compound device
module hub_power_port_config (
  input wire CLK_I,
  input wire RSTN_I,
  input wire CFG_WR_I,
  input wire CFG_RD_I,
  input wire [3:0] CFG_ADDR_I,
  input wire [7:0] CFG_WDATA_I,
  input wire POWER_SOURCE_SELECT_I,
  input wire LOCAL_POWER_SENSE_I,
  input wire OVERCURRENT_I,
  output reg [7:0] CFG_RDATA_O,
  output reg SELF_POWERED_O,
  output reg COMPOUND_O,
  output reg [2:1] PORT_FIXED_O,
  output reg [2:1] PORT_DISABLED_O,
  output reg [7:0] UPSTREAM_CURRENT_O,
  output reg [1:0] OVERCURRENT_DELAY_SELECT_O,
  output reg OVERCURRENT_FAULT_O
);
  // ========================================================
  // configuration bytes
  reg [7:0] power_timer_options;
  reg [7:0] fixed_port_flags;
  reg [7:0] port_off_self_powered;
  reg [7:0] port_off_bus_powered;
  reg [7:0] upstream_current_self_powered;
  reg [7:0] upstream_current_bus_powered;

  // ========================================================
  // pin synchronisers
  wire [2:0] pin_raw;
  wire [2:0] pin_sync;
  wire sense_pin;
  wire oc_pin;
  wire select_pin;

  assign pin_raw = {POWER_SOURCE_SELECT_I, OVERCURRENT_I,
    LOCAL_POWER_SENSE_I};
  // one two-stage synchroniser per pin; only stage b is read
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_sync
      reg stage_a;
      reg stage_b;
      always @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else begin
          stage_a <= pin_raw[s];
          stage_b <= stage_a;
        end
      end
      assign pin_sync[s] = stage_b;
    end
  endgenerate
  assign sense_pin = pin_sync[0];
  assign oc_pin = pin_sync[1];
  assign select_pin = pin_sync[2];

  // ========================================================
  // write decode; one enable per byte
  wire wr_options;
  wire wr_fixed;
  wire wr_off_self;
  wire wr_off_bus;
  wire wr_cur_self;
  wire wr_cur_bus;
  wire [7:0] wdata_ports;

  // decoded once so each byte register sees a single enable
  assign wr_options = CFG_WR_I & (CFG_ADDR_I == `OFS_POWER_TIMER_OPTIONS);
  assign wr_fixed = CFG_WR_I & (CFG_ADDR_I == `OFS_FIXED_PORT_FLAGS);
  assign wr_off_self = CFG_WR_I & (CFG_ADDR_I == `OFS_PORT_OFF_SELF);
  assign wr_off_bus = CFG_WR_I & (CFG_ADDR_I == `OFS_PORT_OFF_BUS);
  assign wr_cur_self = CFG_WR_I & (CFG_ADDR_I == `OFS_CURRENT_SELF);
  assign wr_cur_bus = CFG_WR_I & (CFG_ADDR_I == `OFS_CURRENT_BUS);
  // reserved bits forced to zero on write so reads show them clear
  assign wdata_ports = CFG_WDATA_I & `PORT_MASK;

  // ========================================================
  // power and timer options byte
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      power_timer_options <= `RST_POWER_TIMER_OPTIONS;
    end else if (wr_options) begin
      power_timer_options <= CFG_WDATA_I & `OPTIONS_MASK;
    end
  end

  // ========================================================
  // port flag bytes
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fixed_port_flags <= `RST_FIXED_PORT_FLAGS;
    end else if (wr_fixed) begin
      fixed_port_flags <= wdata_ports;
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port_off_self_powered <= `RST_PORT_OFF_SELF;
    end else if (wr_off_self) begin
      port_off_self_powered <= wdata_ports;
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      port_off_bus_powered <= `RST_PORT_OFF_BUS;
    end else if (wr_off_bus) begin
      port_off_bus_powered <= wdata_ports;
    end
  end

  // ========================================================
  // upstream current bytes
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      upstream_current_self_powered <= `RST_CURRENT_SELF;
    end else if (wr_cur_self) begin
      upstream_current_self_powered <= CFG_WDATA_I;
    end
  end

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      upstream_current_bus_powered <= `RST_CURRENT_BUS;
    end else if (wr_cur_bus) begin
      upstream_current_bus_powered <= CFG_WDATA_I;
    end
  end

  // ========================================================
  // read back; unmapped offsets read zero
  reg [7:0] next_rdata;
  always @* begin
    case (CFG_ADDR_I)
      `OFS_POWER_TIMER_OPTIONS: begin
        next_rdata = power_timer_options;
      end
      `OFS_FIXED_PORT_FLAGS: begin
        next_rdata = fixed_port_flags;
      end
      `OFS_PORT_OFF_SELF: begin
        next_rdata = port_off_self_powered;
      end
      `OFS_PORT_OFF_BUS: begin
        next_rdata = port_off_bus_powered;
      end
      `OFS_CURRENT_SELF: begin
        next_rdata = upstream_current_self_powered;
      end
      `OFS_CURRENT_BUS: begin
        next_rdata = upstream_current_bus_powered;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // ========================================================
  // read data register; holds until the next read
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      CFG_RDATA_O <= 8'h00;
    end else if (CFG_RD_I) begin
      CFG_RDATA_O <= next_rdata;
    end
  end

  // ========================================================
  // power mode decision
  wire dynamic_on;
  wire compound;
  wire next_self;
  assign dynamic_on = power_timer_options[`BIT_DYNAMIC_POWER];
  assign compound = power_timer_options[`BIT_COMPOUND];
  // sense pin rules when switching is on, else the select strap
  assign next_self = dynamic_on ? sense_pin : select_pin;

  // ========================================================
  // per-port selection; follows the power mode every cycle
  wire [2:1] next_fixed;
  wire [2:1] next_disabled;
  wire [7:0] next_current;

  genvar p;
  generate
    for (p = `BIT_PORT1; p <= `BIT_PORT2; p = p + 1) begin : g_port
      // flags meaningless for a standalone hub
      assign next_fixed[p] = compound & fixed_port_flags[p];
      assign next_disabled[p] = next_self ? port_off_self_powered[p] :
        port_off_bus_powered[p];
    end
  endgenerate
  // current limit not policed here; loader owns it
  assign next_current = next_self ? upstream_current_self_powered :
    upstream_current_bus_powered;

  // ========================================================
  // power mode output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SELF_POWERED_O <= 1'b0;
    end else begin
      SELF_POWERED_O <= next_self;
    end
  end

  // ========================================================
  // compound output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      COMPOUND_O <= 1'b0;
    end else begin
      COMPOUND_O <= compound;
    end
  end

  // ========================================================
  // non-removable port output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PORT_FIXED_O <= 2'b00;
    end else begin
      PORT_FIXED_O <= next_fixed;
    end
  end

  // ========================================================
  // disabled port output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PORT_DISABLED_O <= 2'b00;
    end else begin
      PORT_DISABLED_O <= next_disabled;
    end
  end

  // ========================================================
  // upstream current output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      UPSTREAM_CURRENT_O <= 8'h00;
    end else begin
      UPSTREAM_CURRENT_O <= next_current;
    end
  end

  // ========================================================
  // over-current delay code output
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      OVERCURRENT_DELAY_SELECT_O <= 2'b01;
    end else begin
      OVERCURRENT_DELAY_SELECT_O <=
        power_timer_options[`FLD_OC_DELAY_HI:`FLD_OC_DELAY_LO];
    end
  end

  // ========================================================
  // over-current timer
  wire oc_fault;
  oc_delay_counter u_oc (
    .clk(CLK_I),
    .rstn(RSTN_I),
    .delay_select(power_timer_options[`FLD_OC_DELAY_HI:`FLD_OC_DELAY_LO]),
    .sense(oc_pin),
    .fault(oc_fault)
  );

  // ========================================================
  // fault output; registered so the pin never glitches

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      OVERCURRENT_FAULT_O <= 1'b0;
    end else begin
      OVERCURRENT_FAULT_O <= oc_fault;
    end
  end
endmodule

// *** hub_cfg_map.vh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: core clock of 200 MHz (5 ns period)
// Notes: times kept in microseconds times ten, counts derived from them
`ifndef HUB_CFG_MAP_VH
`define HUB_CFG_MAP_VH

// ==========================================================
// byte offsets in the configuration space
`define OFS_POWER_TIMER_OPTIONS 4'h7
`define OFS_FIXED_PORT_FLAGS 4'h8
`define OFS_PORT_OFF_SELF 4'h9
`define OFS_PORT_OFF_BUS 4'ha
`define OFS_CURRENT_SELF 4'hb
`define OFS_CURRENT_BUS 4'hc

// ==========================================================
// field positions
`define BIT_DYNAMIC_POWER 7
`define BIT_COMPOUND 3
`define FLD_OC_DELAY_HI 5
`define FLD_OC_DELAY_LO 4
`define BIT_PORT1 1
`define BIT_PORT2 2
`define PORT_MASK 8'h06
`define OPTIONS_MASK 8'hb8

// ==========================================================
// reset values
`define RST_POWER_TIMER_OPTIONS 8'h90
`define RST_FIXED_PORT_FLAGS 8'h00
`define RST_PORT_OFF_SELF 8'h00
`define RST_PORT_OFF_BUS 8'h00
`define RST_CURRENT_SELF 8'h01
`define RST_CURRENT_BUS 8'h64

// ==========================================================
// over-current delays in units of 0.1 us
`define OC_TIME_0_TENTH_US 1000
`define OC_TIME_1_TENTH_US 20000
`define OC_TIME_2_TENTH_US 40000
`define OC_TIME_3_TENTH_US 60000
`define CLK_PERIOD_NS 5
// the same delays as core clock cycles, sized for the timer
`define OC_LIMIT_0 21'h004e20
`define OC_LIMIT_1 21'h061a80
`define OC_LIMIT_2 21'h0c3500
`define OC_LIMIT_3 21'h124f80
`define OC_CYCLES(t) (((t) * 100) / `CLK_PERIOD_NS)

`endif

// *** oc_delay_counter.v ***
// Purpose: over-current qualification timer
// Assumes: over-current input already synchronised
// Notes: fault reported after the input held for the full delay
`timescale 1ns/10ps
`include "hub_cfg_map.vh"
module oc_delay_counter (
  input wire clk,
  input wire rstn,
  input wire [1:0] delay_select,
  input wire sense,
  output reg fault
);
  // ========================================================
  // delay table
  reg [20:0] limit;
  reg [20:0] count;

  always @* begin
    case (delay_select)
      2'b00: limit = `OC_LIMIT_0;
      2'b01: limit = `OC_LIMIT_1;
      2'b10: limit = `OC_LIMIT_2;
      2'b11: limit = `OC_LIMIT_3;
      default: limit = `OC_LIMIT_1;
    endcase
  end

  // ========================================================
  // counter; a short glitch restarts the wait
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 21'h000000;
      fault <= 1'b0;
    end else if (!sense) begin
      count <= 21'h000000;
      fault <= 1'b0;
    end else if (count >= limit - 21'h000001) begin
      fault <= 1'b1;
    end else begin
      count <= count + 21'h000001;
    end
  end
endmodule

// *** cfg_loader.sv ***
// Purpose: loader model for the power and port bytes
// Assumes: strobes change just after the rising edge
// Notes: one byte per strobe, never back to back
`timescale 1ns/10ps
module cfg_loader (
  input wire clk_i,
  output reg wr_o,
  output reg rd_o,
  output reg [3:0] addr_o,
  output reg [7:0] wdata_o
);
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = 14'h0;
  end
  // ==========================================
  // byte transfers
  task put(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      // self-powered upstream current (byte 0xb) capped at 100 mA; bus-powered byte 0xc passes unchanged
      wdata_o <= (a == 4'hb && d > 8'h32) ? 8'h32 : d;
      @(posedge clk_i);
      wr_o <= 1'b0;
    end
  endtask
  task get(input [3:0] a);
    begin
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
    end
  endtask
endmodule

// *** hub_cfg_properties.sv ***
// Purpose: port-level checks of the power and port bytes
// Assumes: writes spaced at least two cycles apart
// Notes: shadow bytes rebuilt from the write strobes
`timescale 1ns/10ps
module hub_cfg_properties (
  input wire CLK_I,
  input wire RSTN_I,
  input wire CFG_WR_I,
  input wire [3:0] CFG_ADDR_I,
  input wire [7:0] CFG_WDATA_I,
  input wire POWER_SOURCE_SELECT_I,
  input wire LOCAL_POWER_SENSE_I,
  input wire OVERCURRENT_I,
  input wire SELF_POWERED_O,
  input wire COMPOUND_O,
  input wire [2:1] PORT_FIXED_O,
  input wire [2:1] PORT_DISABLED_O,
  input wire [7:0] UPSTREAM_CURRENT_O,
  input wire [1:0] OVERCURRENT_DELAY_SELECT_O,
  input wire OVERCURRENT_FAULT_O
);
  reg [7:0] b [7:12];
  reg [17:0] run;
  integer k;
  // ==========================================
  // shadow bytes and over-current run length
  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (k = 8; k <= 10; k = k + 1) begin
        b[k] <= 8'h00;
      end
      b[7] <= 8'h90;
      b[11] <= 8'h01;
      b[12] <= 8'h64;
      run <= 18'h0;
    end else begin
      if (CFG_WR_I && CFG_ADDR_I >= 4'h7 && CFG_ADDR_I <= 4'hc) begin
        b[CFG_ADDR_I] <= CFG_WDATA_I;
      end
      // saturates so a long fault never wraps back under the limit
      run <= !OVERCURRENT_I ? 18'h0 : run + {17'h0, run != 18'h3ffff};
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_delay_write: assert property (CFG_WR_I && CFG_ADDR_I == 4'h7 |-> ##2
    OVERCURRENT_DELAY_SELECT_O == b[7][5:4]) else $error("delay code");
  a_compound_write: assert property (CFG_WR_I && CFG_ADDR_I == 4'h7 |->
    ##2 COMPOUND_O == b[7][3]) else $error("compound flag");
  a_fixed_gate: assert property (!COMPOUND_O |-> PORT_FIXED_O == 2'b00)
    else $error("fixed ports without compound");
  a_fixed_flags: assert property ((!CFG_WR_I)[*3] ##0 COMPOUND_O |->
    PORT_FIXED_O == b[8][2:1]) else $error("fixed ports");
  a_dynamic_sense: assert property ((b[7][7] &&
    $stable(LOCAL_POWER_SENSE_I))[*5] |-> SELF_POWERED_O ==
    LOCAL_POWER_SENSE_I) else $error("dynamic mode");
  a_static_select: assert property ((!b[7][7] &&
    $stable(POWER_SOURCE_SELECT_I))[*5] |-> SELF_POWERED_O ==
    POWER_SOURCE_SELECT_I) else $error("static mode");
  a_port_off_mode: assert property (($stable(SELF_POWERED_O) &&
    !CFG_WR_I)[*3] |-> PORT_DISABLED_O == (SELF_POWERED_O ? b[9][2:1] :
    b[10][2:1])) else $error("disabled ports");
  a_current_mode: assert property (($stable(SELF_POWERED_O) &&
    !CFG_WR_I)[*3] |-> UPSTREAM_CURRENT_O == (SELF_POWERED_O ? b[11] :
    b[12])) else $error("upstream current");
  a_oc_early: assert property ($rose(OVERCURRENT_FAULT_O) |->
    run >= 18'd20000) else $error("fault too early");
  a_oc_clear: assert property ((!OVERCURRENT_I)[*8] |->
    !OVERCURRENT_FAULT_O) else $error("fault stuck");
endmodule
bind hub_power_port_config hub_cfg_properties chk (.CLK_I, .RSTN_I,
  .CFG_WR_I, .CFG_ADDR_I, .CFG_WDATA_I, .POWER_SOURCE_SELECT_I,
  .LOCAL_POWER_SENSE_I, .OVERCURRENT_I, .SELF_POWERED_O, .COMPOUND_O,
  .PORT_FIXED_O, .PORT_DISABLED_O, .UPSTREAM_CURRENT_O,
  .OVERCURRENT_DELAY_SELECT_O, .OVERCURRENT_FAULT_O);

// *** hub_power_port_config_bench.sv ***
// Purpose: self-checking bench for the power and port byte bank
// Assumes: loader model drives the byte strobes
// Notes: only the shortest over-current delay is timed, to keep runs short
`timescale 1ns/10ps
module hub_power_port_config_bench;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg sel = 1'b0;
  reg sense = 1'b1;
  reg oc = 1'b0;
  wire wr, rd, self_o, comp, flt;
  wire [3:0] addr;
  wire [7:0] wdata, rdata, cur;
  wire [2:1] fixd, dis;
  wire [1:0] dsel;
  integer errors = 0;
  integer checked = 0;
  integer i;
  always #2.5 clk = ~clk;
  cfg_loader ld (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
    .wdata_o(wdata));
  hub_power_port_config dut (.CLK_I(clk), .RSTN_I(rstn), .CFG_WR_I(wr),
    .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_WDATA_I(wdata),
    .POWER_SOURCE_SELECT_I(sel), .LOCAL_POWER_SENSE_I(sense),
    .OVERCURRENT_I(oc), .CFG_RDATA_O(rdata), .SELF_POWERED_O(self_o),
    .COMPOUND_O(comp), .PORT_FIXED_O(fixd), .PORT_DISABLED_O(dis),
    .UPSTREAM_CURRENT_O(cur), .OVERCURRENT_DELAY_SELECT_O(dsel),
    .OVERCURRENT_FAULT_O(flt));
  // ==========================================
  // shared tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
    end
  endtask
  task rdchk(input [3:0] a, input [7:0] exp);
    begin
      ld.get(a);
      @(posedge clk);
      #1;
      chk(rdata, exp);
    end
  endtask
  task wait_n(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    begin
      chk(cur, 8'h01);
      chk({6'h0, dsel}, 8'h01);
      chk({7'h0, self_o}, 8'h01);
      chk({7'h0, comp}, 8'h00);
      rdchk(4'h7, 8'h90);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      for (i = 7; i <= 15; i = i + 1) begin
        ld.put(i[3:0], 8'hff);
      end
      rdchk(4'h7, 8'hb8);
      rdchk(4'h8, 8'h06);
      rdchk(4'h9, 8'h06);
      rdchk(4'ha, 8'h06);
      rdchk(4'hb, 8'h32);
      rdchk(4'hc, 8'hff);
      rdchk(4'hf, 8'h00);
      $display("register test done");
    end
  endtask
  task t_modes;
    begin
      ld.put(4'h8, 8'h06);
      ld.put(4'h9, 8'h02);
      ld.put(4'ha, 8'h04);
      // embedded function current folded into both bytes
      ld.put(4'hb, 8'h19);
      ld.put(4'hc, 8'h7d);
      ld.put(4'h7, 8'h88);
      wait_n(3);
      chk(cur, 8'h19);
      chk({6'h0, dis}, 8'h01);
      chk({6'h0, fixd}, 8'h03);
      @(posedge clk) sense <= 1'b0;
      wait_n(5);
      chk({7'h0, self_o}, 8'h00);
      chk(cur, 8'h7d);
      chk({6'h0, dis}, 8'h02);
      ld.put(4'h7, 8'h00);
      sense <= 1'b1;
      wait_n(5);
      chk({7'h0, self_o}, 8'h00);
      chk({6'h0, fixd}, 8'h00);
      chk({7'h0, comp}, 8'h00);
      @(posedge clk) sel <= 1'b1;
      wait_n(5);
      chk({7'h0, self_o}, 8'h01);
      chk({6'h0, dis}, 8'h01);
      $display("mode test done");
    end
  endtask
  task t_oc;
    begin
      ld.put(4'h7, 8'h80);
      oc <= 1'b1;
      wait_n(19990);
      chk({6'h0, dsel}, 8'h00);
      chk({7'h0, flt}, 8'h00);
      for (i = 0; i < 40 && flt !== 1'b1; i = i + 1) begin
        wait_n(1);
      end
      chk({7'h0, flt}, 8'h01);
      @(posedge clk) oc <= 1'b0;
      wait_n(8);
      chk({7'h0, flt}, 8'h00);
      ld.put(4'h7, 8'ha0);
      wait_n(2);
      chk({6'h0, dsel}, 8'h02);
      $display("over-current test done");
    end
  endtask
  task test_done;
    begin
      $display("checked %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wait_n(6);
    t_reset;
    t_regs;
    t_modes;
    t_oc;
    test_done;
  end
  initial begin
    #300000;
    errors = errors + 1;
    test_done;
  end
endmodule
